// file: src/chan_seq_pkg.sv
package chan_seq_pkg;

  // Register addresses on the serial port.
  localparam logic [5:0] CHAN_BASE_ADDR = 6'h09;
  localparam logic [5:0] CHAN_LAST_ADDR = 6'h18;
  localparam logic [5:0] STATUS_ADDR = 6'h00;
  localparam logic [5:0] DATA_ADDR = 6'h02;

  // Channel register count and reset values.
  localparam int NUM_CHAN = 16;
  localparam logic [15:0] CHAN0_RESET = 16'h8001;
  localparam logic [15:0] CHAN_RESET = 16'h0001;

  // Channel register field positions.
  localparam int ENABLE_BIT = 15;
  localparam int SETUP_HI = 14;
  localparam int SETUP_LO = 12;
  localparam int POS_HI = 9;
  localparam int POS_LO = 5;
  localparam int NEG_HI = 4;
  localparam int NEG_LO = 0;

  // Command byte fields: bit 7 must be low, bit 6 selects a read.
  localparam int CMD_NWEN_BIT = 7;
  localparam int CMD_READ_BIT = 6;
  localparam logic [7:0] CMD_IDLE = 8'hff;

  // Serial frame bit counts.
  localparam logic [5:0] CMD_LAST_BIT = 6'h07;
  localparam logic [5:0] WR_LAST_BIT = 6'h17;
  localparam logic [5:0] CNT_MAX = 6'h3f;

  // Input selector codes for internal sources.
  localparam logic [4:0] SRC_TEMP = 5'h10;
  localparam logic [4:0] SRC_NEG_SUPPLY = 5'h11;
  localparam logic [4:0] SRC_REF = 5'h12;
  localparam logic [4:0] SRC_DIGITAL_GROUND = 5'h13;
  localparam logic [4:0] SRC_EXT_LAST = 5'h0f;

  // Internal source one-hot positions.
  localparam int INT_TEMP = 0;
  localparam int INT_NEG_SUPPLY = 1;
  localparam int INT_REF = 2;
  localparam int INT_DIGITAL_GROUND = 3;

  // Sequencer states, Gray coded.
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_RUN = 2'b01
  } seq_state_t;

endpackage

// file: src/next_chan_find.sv
`timescale 1ns/1ps
`default_nettype none
module next_chan_find (
  input wire logic [15:0] en_mask,
  input wire logic [3:0] cur,
  output logic [3:0] next_ch,
  output logic any_en
);

  // Returns found flag and index of the lowest set bit.
  function automatic logic [4:0] lowest_set(input logic [15:0] m);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (m[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  logic [15:0] above_mask;
  logic [4:0] above_hit;
  logic [4:0] wrap_hit;

  // Prefer the lowest enabled channel above the current one, else wrap.
  assign above_mask = en_mask & (16'hfffe << cur);
  assign above_hit = lowest_set(above_mask);
  assign wrap_hit = lowest_set(en_mask);
  assign next_ch = above_hit[4] ? above_hit[3:0] : wrap_hit[3:0];
  assign any_en = wrap_hit[4];

endmodule
`default_nettype wire

// file: src/input_route_dec.sv
`timescale 1ns/1ps
`default_nettype none
module input_route_dec (
  input wire logic [4:0] code,
  output logic [15:0] ext_sel,
  output logic [3:0] int_sel
);

  // One line per external analog input.
  for (genvar g = 0; g < 16; g++) begin : g_ext
    assign ext_sel[g] = (code == 5'(g));
  end

  // Internal sources above the external input codes.
  assign int_sel[chan_seq_pkg::INT_TEMP] =
    (code == chan_seq_pkg::SRC_TEMP);
  assign int_sel[chan_seq_pkg::INT_NEG_SUPPLY] =
    (code == chan_seq_pkg::SRC_NEG_SUPPLY);
  assign int_sel[chan_seq_pkg::INT_REF] =
    (code == chan_seq_pkg::SRC_REF);
  assign int_sel[chan_seq_pkg::INT_DIGITAL_GROUND] =
    (code == chan_seq_pkg::SRC_DIGITAL_GROUND);

endmodule
`default_nettype wire

// file: src/channel_sequencer_config.sv
// Functional notes
// - Sixteen channel registers at consecutive addresses 0x09 through 0x18.
// - Reset loads 0x8001 into channel zero, 0x0001 into the others.
// - While converting, step through every enabled channel with its config.
// - Bit 15 enables; order runs lowest enabled upward, then wraps.
// - Each written result tags its channel number into status bits 3:0.
// - With status append on, status follows each result read.
// - Bits 14:12 pick one of eight setups for the channel.
// - Bits 9:5 pick the positive input; codes 0 to 15 are inputs.
// - Several channels may share the same setup index.
// - Codes 0x10 to 0x13 route temperature, supply, reference, ground.
`timescale 1ns/1ps
`default_nettype none
module channel_sequencer_config (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe_n,
  input wire logic status_append,
  input wire logic conv_run,
  input wire logic result_valid,
  input wire logic [23:0] result_data,
  output logic conv_active,
  output logic [3:0] active_chan,
  output logic [2:0] active_setup,
  output logic [4:0] pos_input_sel,
  output logic [4:0] neg_input_sel,
  output logic [15:0] pos_ext,
  output logic [3:0] pos_int,
  output logic [15:0] neg_ext,
  output logic [3:0] neg_int,
  output logic [7:0] status_out
);

  // True when an address falls on one of the channel registers.
  function automatic logic in_chan_range(input logic [5:0] a);
    return (a >= chan_seq_pkg::CHAN_BASE_ADDR) &&
           (a <= chan_seq_pkg::CHAN_LAST_ADDR);
  endfunction

  logic [2:0] sclk_s_ff;
  logic [1:0] cs_s_ff;
  logic [1:0] sdi_s_ff;
  logic [5:0] bit_cnt_ff;
  logic [7:0] cmd_ff;
  logic [15:0] rx_ff;
  logic [31:0] tx_ff;
  logic sdo_oe_n_ff;
  logic [15:0] chan_cfg_ff [16];
  logic [7:0] status_ff;
  logic [23:0] result_ff;
  logic [3:0] active_chan_ff;
  chan_seq_pkg::seq_state_t state_ff;
  chan_seq_pkg::seq_state_t nxt_state;

  // Pin synchronisers; only the second and third stages feed logic.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_s_ff <= 3'h7;
      cs_s_ff <= 2'h3;
      sdi_s_ff <= 2'h0;
    end else begin
      sclk_s_ff <= {sclk_s_ff[1:0], sclk};
      cs_s_ff <= {cs_s_ff[0], cs_n};
      sdi_s_ff <= {sdi_s_ff[0], sdi};
    end
  end

  logic sclk_rise;
  logic cs_act;
  logic rx_bit;
  logic [7:0] cmd_next;
  logic at_cmd;
  logic cmd_ok;
  logic load_rd;
  logic [5:0] rd_addr;
  logic [3:0] rd_idx;
  logic [31:0] rd_word;
  logic wr_chan;
  logic [5:0] wr_addr;
  logic [3:0] wr_idx;
  logic [15:0] wr_data;

  // Serial frame decode: command byte first, then data, MSB first.
  assign sclk_rise = sclk_s_ff[1] & ~sclk_s_ff[2];
  assign cs_act = ~cs_s_ff[1];
  assign rx_bit = sdi_s_ff[1];
  assign cmd_next = {rx_ff[6:0], rx_bit};
  assign at_cmd = cs_act && sclk_rise &&
                  (bit_cnt_ff == chan_seq_pkg::CMD_LAST_BIT);
  assign cmd_ok = ~cmd_next[chan_seq_pkg::CMD_NWEN_BIT];
  assign load_rd = at_cmd && cmd_ok &&
                   cmd_next[chan_seq_pkg::CMD_READ_BIT];
  assign rd_addr = cmd_next[5:0];
  assign rd_idx = 4'(rd_addr - chan_seq_pkg::CHAN_BASE_ADDR);
  assign wr_addr = cmd_ff[5:0];
  assign wr_idx = 4'(wr_addr - chan_seq_pkg::CHAN_BASE_ADDR);
  assign wr_data = {rx_ff[14:0], rx_bit};
  assign wr_chan = cs_act && sclk_rise &&
                   (bit_cnt_ff == chan_seq_pkg::WR_LAST_BIT) &&
                   !cmd_ff[chan_seq_pkg::CMD_NWEN_BIT] &&
                   !cmd_ff[chan_seq_pkg::CMD_READ_BIT] &&
                   in_chan_range(wr_addr);

  // Read word, left aligned; status follows the result when asked.
  assign rd_word = in_chan_range(rd_addr) ?
                     {chan_cfg_ff[rd_idx], 16'h0000} :
                   (rd_addr == chan_seq_pkg::STATUS_ADDR) ?
                     {status_ff, 24'h000000} :
                   (rd_addr == chan_seq_pkg::DATA_ADDR) ?
                     {result_ff, status_append ? status_ff : 8'h00} :
                   32'h00000000;

  // Bit counter, command latch and receive shifter.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_ff <= 6'h00;
      cmd_ff <= chan_seq_pkg::CMD_IDLE;
      rx_ff <= 16'h0000;
    end else if (!cs_act) begin
      bit_cnt_ff <= 6'h00;
      cmd_ff <= chan_seq_pkg::CMD_IDLE;
    end else if (sclk_rise) begin
      if (bit_cnt_ff != chan_seq_pkg::CNT_MAX) begin
        bit_cnt_ff <= bit_cnt_ff + 6'h01;
      end
      if (at_cmd) begin
        cmd_ff <= cmd_next;
      end
      rx_ff <= {rx_ff[14:0], rx_bit};
    end
  end

  // Transmit shifter: loaded after the command, shifted on each data edge.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_ff <= 32'h00000000;
      sdo_oe_n_ff <= 1'b1;
    end else begin
      sdo_oe_n_ff <= cs_s_ff[1];
      if (load_rd) begin
        tx_ff <= rd_word;
      end else if (sclk_rise && cs_act &&
                   bit_cnt_ff > chan_seq_pkg::CMD_LAST_BIT) begin
        tx_ff <= {tx_ff[30:0], 1'b0};
      end
    end
  end

  assign sdo = tx_ff[31];
  assign sdo_oe_n = sdo_oe_n_ff;

  // Channel registers; the host keeps reserved bits 11:10 at zero.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < chan_seq_pkg::NUM_CHAN; i++) begin
        chan_cfg_ff[i] <= (i == 0) ? chan_seq_pkg::CHAN0_RESET :
                                     chan_seq_pkg::CHAN_RESET;
      end
    end else if (wr_chan) begin
      chan_cfg_ff[wr_idx] <= wr_data;
    end
  end

  logic [15:0] en_mask;
  logic [3:0] find_cur;
  logic [3:0] next_ch;
  logic any_en;
  logic advance;

  // Enable bits of all channels.
  for (genvar g = 0; g < 16; g++) begin : g_en
    assign en_mask[g] = chan_cfg_ff[g][chan_seq_pkg::ENABLE_BIT];
  end

  // From idle, searching above channel 15 yields the lowest enabled one.
  assign find_cur = (state_ff == chan_seq_pkg::SEQ_IDLE) ? 4'hf :
                    active_chan_ff;

  next_chan_find u_find (
    .en_mask(en_mask),
    .cur(find_cur),
    .next_ch(next_ch),
    .any_en(any_en)
  );

  // Sequencer state: run while converting and any channel is enabled.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      chan_seq_pkg::SEQ_IDLE: begin
        if (conv_run && any_en) begin
          nxt_state = chan_seq_pkg::SEQ_RUN;
        end
      end
      chan_seq_pkg::SEQ_RUN: begin
        if (!conv_run || !any_en) begin
          nxt_state = chan_seq_pkg::SEQ_IDLE;
        end
      end
      default: begin
        nxt_state = chan_seq_pkg::SEQ_IDLE;
      end
    endcase
  end

  assign advance = (state_ff == chan_seq_pkg::SEQ_RUN) && result_valid;

  // Active channel, result capture and status channel tag.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= chan_seq_pkg::SEQ_IDLE;
      active_chan_ff <= 4'h0;
      status_ff <= 8'h00;
      result_ff <= 24'h000000;
    end else begin
      state_ff <= nxt_state;
      if ((state_ff == chan_seq_pkg::SEQ_IDLE) &&
          (nxt_state == chan_seq_pkg::SEQ_RUN)) begin
        active_chan_ff <= next_ch;
      end else if (advance) begin
        active_chan_ff <= next_ch;
      end
      if (advance) begin
        status_ff <= {4'h0, active_chan_ff};
        result_ff <= result_data;
      end
    end
  end

  // Active channel configuration; channels may share a setup index.
  assign conv_active = (state_ff == chan_seq_pkg::SEQ_RUN);
  assign active_chan = active_chan_ff;
  assign active_setup = chan_cfg_ff[active_chan_ff]
                        [chan_seq_pkg::SETUP_HI:chan_seq_pkg::SETUP_LO];
  assign pos_input_sel = chan_cfg_ff[active_chan_ff]
                         [chan_seq_pkg::POS_HI:chan_seq_pkg::POS_LO];
  assign neg_input_sel = chan_cfg_ff[active_chan_ff]
                         [chan_seq_pkg::NEG_HI:chan_seq_pkg::NEG_LO];
  assign status_out = status_ff;

  // Both selectors share one code table.
  input_route_dec u_pos_route (
    .code(pos_input_sel),
    .ext_sel(pos_ext),
    .int_sel(pos_int)
  );

  input_route_dec u_neg_route (
    .code(neg_input_sel),
    .ext_sel(neg_ext),
    .int_sel(neg_int)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  logic after_rst_ff;
  logic [15:0] gap_mask;
  logic [15:0] below_mask;

  // Helpers: first edge after reset, and enabled channels skipped over.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      after_rst_ff <= 1'b1;
    end else begin
      after_rst_ff <= 1'b0;
    end
  end

  assign below_mask = en_mask & ((16'h0001 << next_ch) - 16'h0001);
  assign gap_mask = below_mask & (16'hfffe << find_cur);

  reset_vals_a: assert property (after_rst_ff |->
    chan_cfg_ff[0] == chan_seq_pkg::CHAN0_RESET &&
    chan_cfg_ff[9] == chan_seq_pkg::CHAN_RESET)
    else $error("channel registers not at reset values");

  chan_write_a: assert property (wr_chan |=>
    chan_cfg_ff[$past(wr_idx)] == $past(wr_data))
    else $error("channel register write lost");

  status_tag_a: assert property (advance |=>
    status_ff[3:0] == $past(active_chan_ff) && status_ff[7:4] == 4'h0)
    else $error("status channel tag wrong");

  next_enabled_a: assert property (any_en |-> en_mask[next_ch])
    else $error("sequencer picked a disabled channel");

  no_skip_a: assert property (any_en && next_ch > find_cur |->
    gap_mask == 16'h0000)
    else $error("sequencer skipped an enabled channel");

  wrap_low_a: assert property (any_en && next_ch <= find_cur |->
    below_mask == 16'h0000)
    else $error("wrap did not return to lowest channel");

  append_stat_a: assert property (load_rd &&
    rd_addr == chan_seq_pkg::DATA_ADDR && status_append |=>
    tx_ff[7:0] == $past(status_ff) && tx_ff[31:8] == $past(result_ff))
    else $error("status not appended to result");

  pos_route_a: assert property (pos_input_sel <= 5'h08 |->
    pos_ext[pos_input_sel[3:0]] && pos_int == 4'h0)
    else $error("positive input routed wrongly");

  neg_int_a: assert property (neg_input_sel == 5'h12 |->
    neg_int == 4'h4 && neg_ext == 16'h0000)
    else $error("negative internal source routed wrongly");

  wrap_seen_c: cover property (advance && next_ch < active_chan_ff);
  append_read_c: cover property (load_rd && status_append &&
    rd_addr == chan_seq_pkg::DATA_ADDR);
  chan_write_c: cover property (wr_chan && wr_idx == 4'hf);

endmodule
`default_nettype wire

// file: tb/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire logic clk,
  input wire logic sdo,
  input wire logic sdo_oe_n,
  output logic sclk,
  output logic cs_n,
  output logic sdi
);
  logic last_sdo;
  logic sdo_wire;

  // A released data line shows the inverse of its last driven value.
  always_ff @(posedge clk) begin
    if (!sdo_oe_n) begin
      last_sdo <= sdo;
    end
  end
  assign sdo_wire = sdo_oe_n ? ~last_sdo : sdo;

  // The serial clock idles high and the select idles inactive.
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    sdi = 1'b1;
  end

  // One framed transfer: command byte, then nbits of data either way.
  task automatic xfer(input logic [7:0] cmd, input logic [31:0] wd,
                      input int nbits, output logic [31:0] rd);
    logic [39:0] sh;
    sh = {cmd, wd};
    rd = 32'h0;
    if (!cmd[6] && nbits == 16) begin
      sh[27:26] = 2'b00;
    end
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (6) @(posedge clk);
    for (int i = 0; i < 8 + nbits; i++) begin
      sclk <= 1'b0;
      sdi <= sh[39 - i];
      repeat (6) @(posedge clk);
      sclk <= 1'b1;
      if (i >= 8) begin
        rd = {rd[30:0], sdo_wire};
      end
      repeat (6) @(posedge clk);
    end
    cs_n <= 1'b1;
    sdi <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, resetn, sclk, cs_n, sdi, sdo, sdo_oe_n;
  logic status_append, conv_run, result_valid, conv_active;
  logic [23:0] result_data;
  logic [3:0] active_chan, pos_int, neg_int;
  logic [2:0] active_setup;
  logic [4:0] pos_input_sel, neg_input_sel;
  logic [15:0] pos_ext, neg_ext;
  logic [7:0] status_out;
  logic [15:0] cfg [16];
  int n_fail = 0;
  int checked = 0;

  channel_sequencer_config dut_u (.clk(clk), .resetn(resetn),
    .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
    .status_append(status_append), .conv_run(conv_run),
    .result_valid(result_valid), .result_data(result_data),
    .conv_active(conv_active), .active_chan(active_chan),
    .active_setup(active_setup), .pos_input_sel(pos_input_sel),
    .neg_input_sel(neg_input_sel), .pos_ext(pos_ext), .pos_int(pos_int),
    .neg_ext(neg_ext), .neg_int(neg_int), .status_out(status_out));

  spi_host_model host_u (.clk(clk), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
    .sclk(sclk), .cs_n(cs_n), .sdi(sdi));

  // Free-running 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Compares one value and reports a difference at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (n_fail == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Expected selector decode: bits 15:0 external, 19:16 internal.
  function automatic logic [19:0] route(input logic [4:0] c);
    route = 20'h0;
    if (c < 5'h14) begin
      route[c] = 1'b1;
    end
  endfunction

  task automatic check_active(input int ch);
    logic [15:0] v;
    v = cfg[ch];
    check(active_chan, 32'(ch));
    check(active_setup, v[14:12]);
    check(pos_input_sel, v[9:5]);
    check(neg_input_sel, v[4:0]);
    check({pos_int, pos_ext}, route(v[9:5]));
    check({neg_int, neg_ext}, route(v[4:0]));
  endtask

  // Bounded wait for the sequencer to reach the wanted state.
  task automatic wait_active(input logic want);
    int k;
    k = 0;
    while (conv_active !== want && k < 10) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (conv_active !== want) begin
      n_fail++;
      complete_run();
    end
  endtask

  task automatic t_reset();
    logic [31:0] d;
    check_active(0);
    check({conv_active, sdo_oe_n, status_out}, 32'h100);
    for (int i = 0; i < 16; i++) begin
      host_u.xfer({2'b01, 6'(9 + i)}, 32'h0, 16, d);
      check(d[15:0], cfg[i]);
    end
  endtask

  // Every third channel is enabled; enabled channels nine apart share a
  // setup, and the selectors reach internal and unused codes.
  task automatic t_regs();
    logic [31:0] d;
    for (int i = 0; i < 16; i++) begin
      cfg[i] = {(i % 3 == 0), 3'(i % 9), 2'b00, 5'(i + 4), 5'(i + 6)};
      host_u.xfer({2'b00, 6'(9 + i)}, {cfg[i], 16'h0}, 16, d);
    end
    host_u.xfer(8'h08, 32'h5555_0000, 16, d);
    host_u.xfer(8'h19, 32'haaaa_0000, 16, d);
    for (int i = 0; i < 16; i++) begin
      host_u.xfer({2'b01, 6'(9 + i)}, 32'h0, 16, d);
      check(d[15:0], cfg[i]);
    end
    host_u.xfer(8'h48, 32'h0, 16, d);
    check(d[15:0], 32'h0);
    host_u.xfer(8'h59, 32'h0, 16, d);
    check(d[15:0], 32'h0);
  endtask

  // Eight results walk 0,3,6,9,12,15 and wrap back to 0 and 3.
  task automatic t_seq();
    int ch;
    ch = 0;
    conv_run <= 1'b1;
    wait_active(1'b1);
    for (int r = 0; r < 8; r++) begin
      check_active(ch);
      @(posedge clk);
      result_valid <= 1'b1;
      result_data <= 24'ha50000 | 24'(r);
      @(posedge clk);
      result_valid <= 1'b0;
      #1;
      check(status_out, 32'(ch));
      ch = (ch == 15) ? 0 : ch + 3;
    end
    check_active(ch);
    @(posedge clk);
    conv_run <= 1'b0;
    wait_active(1'b0);
    // A restart begins again at the lowest enabled channel.
    @(posedge clk);
    conv_run <= 1'b1;
    wait_active(1'b1);
    check_active(0);
    @(posedge clk);
    conv_run <= 1'b0;
    wait_active(1'b0);
  endtask

  // Data reads with and without the status byte appended.
  task automatic t_append();
    logic [31:0] d;
    @(posedge clk);
    host_u.xfer(8'h42, 32'h0, 32, d);
    check(d, 32'ha5000700);
    status_append <= 1'b1;
    host_u.xfer(8'h42, 32'h0, 32, d);
    check(d, 32'ha5000703);
    host_u.xfer(8'h40, 32'h0, 8, d);
    check(d[7:0], 32'h03);
  endtask

  initial begin
    resetn = 1'b0;
    status_append = 1'b0;
    conv_run = 1'b0;
    result_valid = 1'b0;
    result_data = 24'h0;
    for (int i = 0; i < 16; i++) begin
      cfg[i] = (i == 0) ? 16'h8001 : 16'h0001;
    end
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    t_reset();
    t_regs();
    t_seq();
    t_append();
    complete_run();
  end
endmodule
`default_nettype wire
